/* File: tacbd_pkg.sv */
`default_nettype none
package tacbd_pkg;
   // Command byte field positions
   localparam int CMD_BITS = 8;
   localparam int START_POS = 7;
   localparam int CHAN_MSB = 6;
   localparam int CHAN_LSB = 4;
   localparam int RES_POS = 3;
   localparam int REF_MODE_POS = 2;
   localparam int REF_ON_POS = 1;
   localparam int KEEP_ON_POS = 0;
   localparam logic [7:0] CMD_RESET = 8'h00;
   // Serial clock counts, measured from the start bit rise as index 0
   localparam logic [4:0] ACQ_RISE = 5'h05;
   localparam logic [4:0] LAST_CMD_RISE = 5'h07;
   localparam logic [4:0] START_GAP_12 = 5'h0F;
   localparam logic [4:0] START_GAP_8 = 5'h0B;
   localparam logic [4:0] CNT_MAX = 5'h1F;
   // Conversion widths
   localparam int RES_12 = 12;
   localparam logic [3:0] BITS_12 = 4'hC;
   localparam logic [3:0] BITS_8 = 4'h8;
   localparam int FIFO_DEPTH = 8;
   // Channel table entry: bit 7 marks a touch measurement, bits 3:0 drive the panel
   localparam int MAP_TOUCH_POS = 7;
   localparam logic [7:0][7:0] CHAN_MAP_DEFAULT = {8'h00, 8'h81, 8'h00, 8'h82, 8'h83, 8'h00, 8'h84, 8'h00};
   typedef enum logic [1:0] {RX_HUNT, RX_CMD, RX_CONV} tacbd_rx_state_t;
endpackage
`default_nettype wire

/* File: tacbd_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module tacbd_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clkEn,
   // Filling side
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   // Draining side
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_r;
   logic [AW-1:0] rdPtr_r;
   logic [CW-1:0] count_r;
   logic push;
   logic pop;

   // Handshakes; ready is registered so the source sees a clean level
   assign push = inValid & inReady & clkEn;
   assign pop = outValid & outReady & clkEn;
   assign outValid = (count_r != '0);
   assign outData = mem[rdPtr_r];

   // Storage, no reset needed on the data itself
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wrPtr_r] <= inData;
      end
   end

   // Pointers wrap at the depth, which need not be a power of two
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end else begin
         if (push) begin
            wrPtr_r <= (wrPtr_r == LAST_PTR) ? '0 : wrPtr_r + 1'b1;
         end
         if (pop) begin
            rdPtr_r <= (rdPtr_r == LAST_PTR) ? '0 : rdPtr_r + 1'b1;
         end
      end
   end

   // Occupancy and ready
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         count_r <= '0;
         inReady <= 1'b1;
      end else if (push && !pop) begin
         count_r <= count_r + 1'b1;
         inReady <= (count_r + 1'b1) != FULL_CNT;
      end else if (pop && !push) begin
         count_r <= count_r - 1'b1;
         inReady <= 1'b1;
      end
   end
endmodule // tacbd_fifo
`default_nettype wire

/* File: tacbd_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module tacbd_decoder #(
   parameter logic [7:0][7:0] CHAN_MAP = tacbd_pkg::CHAN_MAP_DEFAULT,
   parameter int RES_WIDTH = tacbd_pkg::RES_12,
   parameter int DEPTH = tacbd_pkg::FIFO_DEPTH
) (
   // Clock, reset and enable
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clkEn,
   // Serial pins
   input wire logic chipSelectN,
   input wire logic serial_clock,
   input wire logic serialDataIn,
   output logic serialDataOut,
   output logic serialDataOutEnN,
   output logic busy,
   output logic busyEnN,
   // Touch detect
   output logic touch_detect_irq_n,
   input wire logic xPlusLevel,
   output logic xPlusPullupOn,
   output logic yMinusGndOn,
   // Analog routing
   output logic [3:0] panelDrivers,
   output logic [2:0] muxChannel,
   output logic refModeSingle,
   // Power control
   output logic refPowerOn,
   output logic adcPowerOn,
   // Converter core
   output logic adcSampleReq,
   output logic adcEightBit,
   input wire logic [RES_WIDTH-1:0] adcResult,
   input wire logic adcResultValid,
   output logic adcResultReady
);
   // Pin synchronisers and edge history
   logic [1:0] sclkSync_r;
   logic [1:0] csSync_r;
   logic [1:0] dinSync_r;
   logic [1:0] xpSync_r;
   logic sclkPrev_r;
   // Command receiver
   tacbd_pkg::tacbd_rx_state_t rxState_r;
   logic [4:0] rxCnt_r;
   logic [4:0] rxCntNxt;
   logic [7:0] rxShift_r;
   logic [7:0] rxNxt;
   logic [7:0] cmd_r;
   logic [2:0] chan_r;
   logic refSingle_r;
   // Conversion sequencing
   logic convPend_r;
   logic loadPend_r;
   logic acqPhase_r;
   logic measActive_r;
   logic penArm_r;
   logic [RES_WIDTH-1:0] outShift_r;
   logic [3:0] outRem_r;
   // Events
   logic csLost;
   logic sclkRise;
   logic sclkFall;
   logic din;
   logic startSeen;
   logic acquire;
   logic cmdDone;
   logic endConv;
   logic newCmdOwns;
   logic [4:0] startGap;
   logic fifoValid;
   logic fifoPop;
   logic [RES_WIDTH-1:0] fifoData;

   // Channel table entry for a channel code
   function automatic logic [7:0] mapEntry(input logic [2:0] ch);
      mapEntry = CHAN_MAP[ch];
   endfunction

   // Whether a channel code is one of the touch panel measurements
   function automatic logic isTouch(input logic [2:0] ch);
      logic [7:0] e;
      e = mapEntry(ch);
      isTouch = e[tacbd_pkg::MAP_TOUCH_POS];
   endfunction

   // Two flip-flops on every pin; the first stage feeds nothing but the second
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         sclkSync_r <= 2'h0;
         csSync_r <= 2'h3;
         dinSync_r <= 2'h0;
         xpSync_r <= 2'h3;
      end else if (clkEn) begin
         sclkSync_r <= {sclkSync_r[0], serial_clock};
         csSync_r <= {csSync_r[0], chipSelectN};
         dinSync_r <= {dinSync_r[0], serialDataIn};
         xpSync_r <= {xpSync_r[0], xPlusLevel};
      end
   end

   // Serial clock history for edge detection
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         sclkPrev_r <= 1'b0;
      end else if (clkEn) begin
         sclkPrev_r <= sclkSync_r[1];
      end
   end

   // Edges count only while selected; clock activity with select high is ignored
   assign csLost = csSync_r[1];
   assign din = dinSync_r[1];
   assign sclkRise = clkEn & ~csLost & sclkSync_r[1] & ~sclkPrev_r;
   assign sclkFall = clkEn & ~csLost & ~sclkSync_r[1] & sclkPrev_r;
   assign rxNxt = {rxShift_r[6:0], din};
   assign rxCntNxt = (rxCnt_r == tacbd_pkg::CNT_MAX) ? rxCnt_r : rxCnt_r + 5'h01;

   // Earliest overlapped start follows the resolution of the running conversion
   assign startGap = cmd_r[tacbd_pkg::RES_POS] ? tacbd_pkg::START_GAP_8 : tacbd_pkg::START_GAP_12;

   // Receiver events
   assign startSeen = sclkRise & din & ((rxState_r == tacbd_pkg::RX_HUNT) ||
      ((rxState_r == tacbd_pkg::RX_CONV) && (rxCntNxt >= startGap - 5'h01)));
   assign acquire = sclkRise & (rxState_r == tacbd_pkg::RX_CMD) & (rxCntNxt == tacbd_pkg::ACQ_RISE);
   assign cmdDone = sclkRise & (rxState_r == tacbd_pkg::RX_CMD) & (rxCntNxt == tacbd_pkg::LAST_CMD_RISE);

   // End of conversion is the fall that follows result bit 1
   assign endConv = sclkFall & (outRem_r == 4'h1);
   assign newCmdOwns = (rxState_r == tacbd_pkg::RX_CMD) && (rxCnt_r >= tacbd_pkg::ACQ_RISE);

   // Command receiver state; select high throws away a partial byte
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         rxState_r <= tacbd_pkg::RX_HUNT;
         rxCnt_r <= 5'h00;
         rxShift_r <= 8'h00;
      end else if (clkEn) begin
         if (csLost) begin
            rxState_r <= tacbd_pkg::RX_HUNT;
            rxCnt_r <= 5'h00;
         end else if (startSeen) begin
            rxState_r <= tacbd_pkg::RX_CMD;
            rxCnt_r <= 5'h00;
            rxShift_r <= 8'h01;
         end else if (sclkRise) begin
            case (rxState_r)
               tacbd_pkg::RX_CMD: begin
                  rxShift_r <= rxNxt;
                  rxCnt_r <= rxCntNxt;
                  if (cmdDone) begin
                     rxState_r <= tacbd_pkg::RX_CONV;
                  end
               end
               tacbd_pkg::RX_CONV: begin
                  rxCnt_r <= rxCntNxt;
               end
               default: begin
                  rxCnt_r <= 5'h00;
               end
            endcase
         end
      end
   end

   // Routing fields are taken as soon as the reference bit is in
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         chan_r <= 3'h0;
         refSingle_r <= 1'b0;
      end else if (acquire) begin
         chan_r <= rxNxt[tacbd_pkg::CHAN_MSB-2:tacbd_pkg::CHAN_LSB-2];
         refSingle_r <= rxNxt[tacbd_pkg::REF_MODE_POS-2];
      end
   end

   // Whole command held from its last bit; resolution and converter power apply from here
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         cmd_r <= tacbd_pkg::CMD_RESET;
      end else if (cmdDone) begin
         cmd_r <= rxNxt;
      end
   end

   // Sample and busy sequencing; select high abandons the conversion
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         convPend_r <= 1'b0;
         loadPend_r <= 1'b0;
         acqPhase_r <= 1'b0;
         busy <= 1'b0;
         adcSampleReq <= 1'b0;
      end else if (clkEn) begin
         adcSampleReq <= 1'b0;
         if (csLost) begin
            convPend_r <= 1'b0;
            loadPend_r <= 1'b0;
            acqPhase_r <= 1'b0;
            busy <= 1'b0;
         end else begin
            if (acquire) begin
               acqPhase_r <= 1'b1;
            end
            if (cmdDone) begin
               convPend_r <= 1'b1;
            end else if (sclkFall && convPend_r) begin
               convPend_r <= 1'b0;
               loadPend_r <= 1'b1;
               acqPhase_r <= 1'b0;
               busy <= 1'b1;
               adcSampleReq <= 1'b1;
            end else if (sclkFall && loadPend_r) begin
               loadPend_r <= 1'b0;
               busy <= 1'b0;
            end
         end
      end
   end

   // Reference power follows the command only at the busy rise, never on deselect
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         refPowerOn <= 1'b0;
      end else if (sclkFall && convPend_r) begin
         refPowerOn <= cmd_r[tacbd_pkg::REF_ON_POS];
      end
   end

   // Result words wait here so a slow serial reader back-pressures the core
   assign fifoPop = sclkFall & loadPend_r;
   tacbd_fifo #(
      .WIDTH(RES_WIDTH),
      .DEPTH(DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .clkEn(clkEn),
      .inData(adcResult),
      .inValid(adcResultValid),
      .inReady(adcResultReady),
      .outData(fifoData),
      .outValid(fifoValid),
      .outReady(fifoPop)
   );

   // Result shifter; an empty buffer reads as zeros rather than stalling the pins
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         outShift_r <= '0;
         outRem_r <= 4'h0;
         serialDataOut <= 1'b0;
      end else if (clkEn) begin
         if (csLost) begin
            outRem_r <= 4'h0;
            serialDataOut <= 1'b0;
         end else if (fifoPop) begin
            outShift_r <= fifoValid ? {fifoData[RES_WIDTH-2:0], 1'b0} : '0;
            outRem_r <= (cmd_r[tacbd_pkg::RES_POS] ? tacbd_pkg::BITS_8 : tacbd_pkg::BITS_12) - 4'h1;
            serialDataOut <= fifoValid & fifoData[RES_WIDTH-1];
         end else if (sclkFall) begin
            if (outRem_r != 4'h0) begin
               serialDataOut <= outShift_r[RES_WIDTH-1];
               outShift_r <= {outShift_r[RES_WIDTH-2:0], 1'b0};
               outRem_r <= outRem_r - 4'h1;
            end else begin
               serialDataOut <= 1'b0;
            end
         end
      end
   end

   // Measurement window from acquisition to end of conversion; an overlapped
   // command that is already acquiring keeps the window open
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         measActive_r <= 1'b0;
      end else if (clkEn) begin
         if (csLost) begin
            measActive_r <= 1'b0;
         end else if (acquire) begin
            measActive_r <= 1'b1;
         end else if (endConv && !newCmdOwns) begin
            measActive_r <= 1'b0;
         end
      end
   end

   // Touch detect arming: a keep-on command disarms, end of a conversion without keep-on re-arms
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         penArm_r <= 1'b1;
      end else if (clkEn) begin
         if (cmdDone && rxNxt[tacbd_pkg::KEEP_ON_POS]) begin
            penArm_r <= 1'b0;
         end else if (endConv && !cmd_r[tacbd_pkg::KEEP_ON_POS]) begin
            penArm_r <= 1'b1;
         end
      end
   end

   // Interrupt pin: forced during measurements, otherwise the panel sense level while armed and high when disarmed
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         touch_detect_irq_n <= 1'b1;
      end else if (clkEn) begin
         if (measActive_r) begin
            touch_detect_irq_n <= !isTouch(chan_r);
         end else if (penArm_r) begin
            touch_detect_irq_n <= xpSync_r[1];
         end else begin
            touch_detect_irq_n <= 1'b1;
         end
      end
   end

   // Panel switches; drivers stay on through conversion only when ratiometric
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         xPlusPullupOn <= 1'b1;
         yMinusGndOn <= 1'b1;
         panelDrivers <= 4'h0;
      end else if (clkEn) begin
         xPlusPullupOn <= penArm_r && !(measActive_r && isTouch(chan_r));
         yMinusGndOn <= penArm_r && !measActive_r;
         if (measActive_r && (acqPhase_r || !refSingle_r)) begin
            panelDrivers <= 4'(mapEntry(chan_r));
         end else begin
            panelDrivers <= 4'h0;
         end
      end
   end

   // Routing, converter power and pin enables
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         muxChannel <= 3'h0;
         refModeSingle <= 1'b0;
         adcPowerOn <= 1'b0;
         adcEightBit <= 1'b0;
         serialDataOutEnN <= 1'b1;
         busyEnN <= 1'b1;
      end else if (clkEn) begin
         muxChannel <= chan_r;
         refModeSingle <= refSingle_r;
         adcPowerOn <= measActive_r || cmd_r[tacbd_pkg::KEEP_ON_POS];
         adcEightBit <= cmd_r[tacbd_pkg::RES_POS];
         serialDataOutEnN <= csSync_r[1];
         busyEnN <= csSync_r[1];
      end
   end
endmodule // tacbd_decoder
`default_nettype wire

/* File: tacbd_decoder_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module tacbd_decoder_sva (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Serial pins
   input wire logic chipSelectN,
   input wire logic serialDataOutEnN,
   input wire logic busy,
   // Touch and routing
   input wire logic touch_detect_irq_n,
   input wire logic [2:0] muxChannel,
   input wire logic [3:0] panelDrivers,
   input wire logic refModeSingle,
   // Power and converter
   input wire logic refPowerOn,
   input wire logic adcPowerOn,
   input wire logic adcSampleReq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // Touch flag of the routed channel; only valid with the default table
   wire logic touchChan = tacbd_pkg::CHAN_MAP_DEFAULT[muxChannel][tacbd_pkg::MAP_TOUCH_POS];
   // Deselect must kill the conversion within the sync delay
   chk_abort_clears_busy: assert property (chipSelectN [*6] |-> !busy)
      else $error("busy high while deselected");
   chk_pin_enable_cs: assert property ($stable(chipSelectN) [*4] |-> serialDataOutEnN == chipSelectN)
      else $error("data pin enable not following select");
   // Busy spans one serial period, never shorter, never stuck
   chk_busy_min_len: assert property ($rose(busy) |-> busy [*6])
      else $error("busy pulse too short");
   chk_busy_ends: assert property ($rose(busy) |-> ##[1:20] !busy)
      else $error("busy pulse too long");
   chk_sample_single: assert property (adcSampleReq |=> !adcSampleReq)
      else $error("sample request longer than one cycle");
   chk_sample_at_hold: assert property (adcSampleReq |-> ##[0:1] busy)
      else $error("sample request away from hold instant");
   chk_ref_on_busy: assert property ($changed(refPowerOn) |-> busy)
      else $error("reference changed outside busy rise");
   chk_power_in_conv: assert property (busy |-> adcPowerOn)
      else $error("converter off during conversion");
   // Interrupt forced level depends on the kind of measurement
   chk_irq_low_touch: assert property ($rose(busy) && touchChan |-> !touch_detect_irq_n)
      else $error("irq not forced low in touch measurement");
   chk_irq_high_other: assert property ($rose(busy) && !touchChan |-> touch_detect_irq_n)
      else $error("irq not forced high in other measurement");
   // Ratiometric touch conversions keep the panel powered through the hold
   chk_drivers_ratio: assert property (busy && !refModeSingle && touchChan |-> panelDrivers != 4'h0)
      else $error("touch drivers off in ratiometric conversion");
   cover property ($rose(busy) && touchChan);
   cover property ($fell(touch_detect_irq_n) && !busy);
   cover property ($rose(refPowerOn));
endmodule // tacbd_decoder_sva
bind tacbd_decoder tacbd_decoder_sva i_sva (.sys_clk(sys_clk), .reset_n(reset_n), .chipSelectN(chipSelectN),
   .serialDataOutEnN(serialDataOutEnN), .busy(busy), .touch_detect_irq_n(touch_detect_irq_n),
   .muxChannel(muxChannel), .panelDrivers(panelDrivers), .refModeSingle(refModeSingle),
   .refPowerOn(refPowerOn), .adcPowerOn(adcPowerOn), .adcSampleReq(adcSampleReq));
`default_nettype wire

/* File: tacbd_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tacbd_host_model (
   // Pins driven by the host
   output logic chipSelectN,
   output logic serial_clock,
   output logic serialDataIn,
   // Result pin
   input wire logic serialDataOut
);
   // Idle: deselected, clock parked low
   initial begin
      chipSelectN = 1'b1;
      serial_clock = 1'b0;
      serialDataIn = 1'b0;
   end
   // One frame of n clocks; result sampled late in the high phase for margin
   task automatic xfer(input logic [63:0] din, input int n, input int hp, output logic [63:0] dout);
      dout = '0;
      chipSelectN = 1'b0;
      #(hp);
      for (int i = 0; i < n; i++) begin
         serialDataIn = din[n - 1 - i];
         #(hp);
         serial_clock = 1'b1;
         #(hp);
         dout = {dout[62:0], serialDataOut};
         serial_clock = 1'b0;
      end
      #(hp);
      chipSelectN = 1'b1;
      // Released line must not keep showing the last bit
      serialDataIn = ~serialDataIn;
      #(2 * hp);
   endtask
endmodule // tacbd_host_model
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int FEED = 12;
   localparam int MAX_CYCLES = 20000;
   // Stimulus
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic xPlusLevel = 1'b1;
   logic clkEn = 1'b1;
   logic adcResultValid = 1'b0;
   logic [11:0] adcResult = 12'h000;
   wire logic chipSelectN, serial_clock, serialDataIn;
   // Observed outputs
   logic serialDataOut, serialDataOutEnN, busy, touch_detect_irq_n, yMinusGndOn;
   logic busyEnN, xPlusPullupOn, adcEightBit;
   logic refModeSingle, refPowerOn, adcPowerOn, adcSampleReq, adcResultReady;
   logic [3:0] panelDrivers;
   logic [2:0] muxChannel;
   int failures = 0, n_tests = 0, cycles = 0, nFed = 0, wordIdx = 0;
   logic [63:0] rd;

   always #25 sys_clk = ~sys_clk;

   tacbd_decoder i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn), .chipSelectN(chipSelectN),
      .serial_clock(serial_clock), .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
      .serialDataOutEnN(serialDataOutEnN), .busy(busy), .busyEnN(busyEnN),
      .touch_detect_irq_n(touch_detect_irq_n), .xPlusLevel(xPlusLevel), .xPlusPullupOn(xPlusPullupOn),
      .yMinusGndOn(yMinusGndOn), .panelDrivers(panelDrivers), .muxChannel(muxChannel),
      .refModeSingle(refModeSingle), .refPowerOn(refPowerOn), .adcPowerOn(adcPowerOn),
      .adcSampleReq(adcSampleReq), .adcEightBit(adcEightBit), .adcResult(adcResult),
      .adcResultValid(adcResultValid), .adcResultReady(adcResultReady));
   tacbd_host_model i_host (.chipSelectN(chipSelectN), .serial_clock(serial_clock), .serialDataIn(serialDataIn),
      .serialDataOut(serialDataOut));

   // Converter core: numbered words until FEED, so drain to empty is reachable
   always @(posedge sys_clk) begin
      if (reset_n && adcResultValid && adcResultReady) nFed <= nFed + 1;
   end
   always @(negedge sys_clk) begin
      adcResult <= 12'hA00 + nFed[11:0];
      adcResultValid <= (nFed < FEED);
   end

   // Hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == MAX_CYCLES) begin
         failures++;
         $display("Error timeout expected finish seen hang");
         give_verdict;
      end
   end

   task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Result bits as sampled, for a command whose start lies back clocks before frame end
   function automatic logic [63:0] expRes(input logic [7:0] cmd, input int j, input int back);
      logic [11:0] w;
      w = (j < FEED) ? 12'hA00 + 12'(j) : 12'h000;
      if (cmd[3]) return 64'(w[11:4]) << (back - 17);
      return 64'(w) << (back - 21);
   endfunction

   // Frame with one command, or two spaced by gap clocks
   task automatic run(input logic [7:0] cmdA, input logic [7:0] cmdB, input int gap, input int lead, input int n,
                      input int hp, input string name);
      logic [63:0] din;
      logic [63:0] exp;
      din = 64'(cmdA) << (n - 8 - lead);
      exp = expRes(cmdA, wordIdx, n - lead);
      wordIdx++;
      if (gap > 0) begin
         din |= 64'(cmdB) << (n - 8 - lead - gap);
         exp |= expRes(cmdB, wordIdx, n - lead - gap);
         wordIdx++;
      end
      i_host.xfer(din, n, hp, rd);
      check(name, exp, rd);
      $display("Test %s done", name);
   endtask

   task automatic give_verdict;
      $display("Comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   initial begin
      repeat (16) @(negedge sys_clk);
      reset_n = 1'b1;
      repeat (30) @(negedge sys_clk);
      // Reset state; FIFO filled until it refuses
      check("busy", 64'h0, 64'(busy));
      check("irq", 64'h1, 64'(touch_detect_irq_n));
      check("ref", 64'h0, 64'(refPowerOn));
      check("adc power", 64'h0, 64'(adcPowerOn));
      check("y switch", 64'h1, 64'(yMinusGndOn));
      check("pullup", 64'h1, 64'(xPlusPullupOn));
      check("busy pin", 64'h1, 64'(busyEnN));
      check("fifo full", 64'h0, 64'(adcResultReady));
      // Enable low freezes the pin path, so a touch meanwhile goes unseen
      clkEn = 1'b0;
      xPlusLevel = 1'b0;
      repeat (8) @(negedge sys_clk);
      check("freeze irq", 64'h1, 64'(touch_detect_irq_n));
      clkEn = 1'b1;
      xPlusLevel = 1'b1;
      $display("Test reset done");
      run(8'h84, 8'h00, 0, 3, 27, 200, "lead zeros");
      check("single", 64'h1, 64'(refModeSingle));
      check("res 12", 64'h0, 64'(adcEightBit));
      // Touch channel ratiometric 8-bit, slow host
      run(8'hB8, 8'h00, 0, 0, 24, 400, "ratio 8bit");
      check("mux", 64'h3, 64'(muxChannel));
      check("ratio", 64'h0, 64'(refModeSingle));
      check("res 8", 64'h1, 64'(adcEightBit));
      check("drivers", 64'h0, 64'(panelDrivers));
      // Tightest overlap in both resolutions
      run(8'hA4, 8'hA4, 14, 0, 38, 200, "overlap 15");
      run(8'hAC, 8'hAC, 10, 0, 34, 200, "overlap 11");
      // Every power setting with the panel touched
      @(negedge sys_clk) xPlusLevel = 1'b0;
      for (int pd = 0; pd < 4; pd++) begin
         run(8'h84 | 8'(pd), 8'h00, 0, 0, 24, 200, "power");
         // Irq is read only once the frame is over, as a host masks it while sending
         repeat (8) @(negedge sys_clk);
         check("ref pd", 64'(pd >> 1), 64'(refPowerOn));
         check("adc pd", 64'(pd & 1), 64'(adcPowerOn));
         check("irq pd", 64'(pd & 1), 64'(touch_detect_irq_n));
         check("pullup pd", 64'(~pd & 1), 64'(xPlusPullupOn));
         if ((pd & 1) == 0) check("y switch pd", 64'h1, 64'(yMinusGndOn));
      end
      @(negedge sys_clk) xPlusLevel = 1'b1;
      // Deselect before the command completes, then after busy
      i_host.xfer(64'(8'h84) >> 1, 7, 200, rd);
      check("ref kept", 64'h1, 64'(refPowerOn));
      check("busy abort", 64'h0, 64'(busy));
      i_host.xfer(64'(8'h84) << 4, 12, 200, rd);
      wordIdx++;
      check("ref off", 64'h0, 64'(refPowerOn));
      check("adc abort", 64'h0, 64'(adcPowerOn));
      check("dout off", 64'h1, 64'(serialDataOutEnN));
      check("busy pin off", 64'h1, 64'(busyEnN));
      $display("Test abort done");
      // Drain the FIFO; an empty FIFO shifts zeros
      check("fifo room", 64'h1, 64'(adcResultReady));
      run(8'h84, 8'h00, 0, 0, 24, 200, "drain last");
      run(8'h84, 8'h00, 0, 0, 24, 200, "drain empty");
      give_verdict;
   end
endmodule // tb_top
`default_nettype wire
